// *** hdl/icbx_exec.sv ***
`timescale 1ns/1ps
`include "icbx_cfg.svh"
// Summary of operation
// RULE1: Idle instruction changes no register, flag or memory, takes at least one cycle.
// RULE2: Idle instruction advances the program counter by two.
// RULE3: All-zero halfword decodes as idle, same as copy zero register to itself.
// RULE4: Complement writes inverted first register into second; first stays unchanged.
// RULE5: Complement clears wrap flag, sets negative and null from result, keeps carry, clamp.
// RULE6: Immediate bit invert addresses first register plus sign-extended offset, bit from instruction.
// RULE7: Register bit invert addresses first register, bit from low three bits of second.
// RULE8: Bit invert reads byte, toggles the bit, writes byte back to same address.
// RULE9: Bit invert sets null when bit was zero, keeps other flags.
// RULE10: Bit index zero is the byte's least significant bit, seven the most.
module icbx_exec (
  input  wire logic        ref_clk_in,
  input  wire logic        resetn_in,
  input  wire logic        start_in,
  input  wire logic [31:0] instr_in,
  input  wire logic [31:0] pc_in,
  input  wire logic [31:0] first_reg_data_in,
  input  wire logic [31:0] second_reg_data_in,
  input  wire logic [4:0]  flags_in,
  input  wire logic        mem_ready_in,
  input  wire logic [7:0]  mem_rdata_in,
  output logic             busy_out,
  output logic             done_out,
  output logic             illegal_out,
  output logic [31:0]      next_pc_out,
  output logic             reg_we_out,
  output logic [4:0]       reg_waddr_out,
  output logic [31:0]      reg_wdata_out,
  output logic [4:0]       flags_out,
  output logic             flags_we_out,
  output logic             mem_req_out,
  output logic             mem_we_out,
  output logic [31:0]      mem_addr_out,
  output logic [7:0]       mem_wdata_out
);

  icbx_pkg::icbx_state_t state;

  // Opcode field of a first halfword, shared by the complement and bit invert decoders below.
  function automatic logic [5:0] icbx_opcode(input logic [15:0] half);
    icbx_opcode = half[`ICBX_OPC_HI:`ICBX_OPC_LO];
  endfunction

  // The all-zero halfword is the idle instruction, whatever the second halfword holds.
  function automatic logic icbx_is_idle(input logic [15:0] half);
    icbx_is_idle = (half == `ICBX_IDLE_CODE);
  endfunction

  // Sign-extends the offset field to a full byte address offset.
  function automatic logic [31:0] icbx_sext16(input logic [15:0] value);
    icbx_sext16 = {{`ICBX_SEXT_BITS{value[`ICBX_HALF_MSB]}}, value};
  endfunction

  // One-hot mask of the selected bit; index zero is the least significant bit.
  function automatic logic [7:0] icbx_bit_mask(input logic [2:0] index);
    icbx_bit_mask = `ICBX_BYTE_ONE << index;
  endfunction

  // True when a word is all zeros, used for the null flag.
  function automatic logic icbx_is_zero(input logic [31:0] value);
    icbx_is_zero = (value == `ICBX_ZERO_WORD);
  endfunction

  // Flags after complement: wrap cleared, negative and null from the result, carry and clamp kept.
  function automatic logic [4:0] icbx_cmpl_flags(input logic [4:0] flags, input logic [31:0] result);
    icbx_cmpl_flags                  = flags;
    icbx_cmpl_flags[`ICBX_FLAG_WRAP] = 1'b0;
    icbx_cmpl_flags[`ICBX_FLAG_NEG]  = result[`ICBX_MSB];
    icbx_cmpl_flags[`ICBX_FLAG_NULL] = icbx_is_zero(result);
  endfunction

  // Program counter after an instruction of one or two halfwords.
  function automatic logic [31:0] icbx_pc_after(input logic [31:0] pc, input logic wide);
    icbx_pc_after = wide ? (pc + `ICBX_PC_STEP32) : (pc + `ICBX_PC_STEP16);
  endfunction

  // Either bit invert form; both share the read-modify-write path.
  function automatic logic icbx_uses_mem(input logic imm_form, input logic reg_form);
    icbx_uses_mem = imm_form || reg_form;
  endfunction

  // Flips the bits of a byte that are set in the mask.
  function automatic logic [7:0] icbx_toggle(input logic [7:0] data, input logic [7:0] mask);
    icbx_toggle = data ^ mask;
  endfunction

  // Bit number held in the low bits of a register operand; higher bits are ignored.
  function automatic logic [2:0] icbx_reg_bit(input logic [31:0] word);
    icbx_reg_bit = word[`ICBX_IDX_HI:`ICBX_IDX_LO];
  endfunction

  // Field extraction from the fetched instruction.
  wire [15:0] low_half    = instr_in[`ICBX_HALF0_HI:`ICBX_HALF0_LO];
  wire [15:0] high_half   = instr_in[`ICBX_HALF1_HI:`ICBX_HALF1_LO];
  wire [5:0]  opcode      = icbx_opcode(low_half);
  wire [4:0]  second_idx  = low_half[`ICBX_SECOND_REGISTER_FIELD_HI:`ICBX_SECOND_REGISTER_FIELD_LO];
  wire [1:0]  form_code   = low_half[`ICBX_FORM_HI:`ICBX_FORM_LO];
  wire [2:0]  imm_bit_idx = low_half[`ICBX_BITNO_HI:`ICBX_BITNO_LO];

  // Decoders for the three handled instructions.
  wire is_idle  = icbx_is_idle(low_half); // [RULE3]
  wire is_cmpl  = (opcode == `ICBX_OP_CMPL) && !is_idle;
  wire is_biti  = (opcode == `ICBX_OP_BITI) && (form_code == `ICBX_BITI_SUB); // [RULE6]
  wire is_bitx  = (opcode == `ICBX_OP_EXT) && (high_half == `ICBX_BITX_SUB); // [RULE7]
  wire is_bitop = icbx_uses_mem(is_biti, is_bitx);
  wire is_known = is_idle || is_cmpl || is_bitop;

  // Complement result and its flag effects.
  wire [31:0] cmpl_result = ~first_reg_data_in; // [RULE4]
  wire [4:0]  cmpl_flags  = icbx_cmpl_flags(flags_in, cmpl_result); // [RULE5]

  // Byte address: immediate form adds sign-extended offset, register form uses it directly.
  wire [31:0] offset_ext  = icbx_sext16(high_half);
  wire [31:0] biti_addr   = first_reg_data_in + offset_ext; // [RULE6]
  wire [31:0] bit_addr    = is_biti ? biti_addr : first_reg_data_in; // [RULE7]
  wire [2:0]  bit_sel     = is_biti ? imm_bit_idx : icbx_reg_bit(second_reg_data_in); // [RULE7]

  // Bit select is held from decode so operands may change during memory access.
  logic [2:0] bit_hold;
  wire  [7:0] toggle_mask  = icbx_bit_mask(bit_hold); // [RULE10]
  wire        prior_bit    = |(mem_rdata_in & toggle_mask);
  wire  [7:0] toggled_byte = icbx_toggle(mem_rdata_in, toggle_mask);

  // Busy from the cycle after an accepted start until the sequencer is back at rest.
  assign busy_out = (state != icbx_pkg::ICBX_IDLE);

  // Bit number capture at an accepted start of a bit invert form.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bit_hold <= 3'h0;
    end else if ((state == icbx_pkg::ICBX_IDLE) && start_in && is_bitop) begin
      bit_hold <= bit_sel;
    end
  end

  // Unknown encodings raise a one-cycle pulse in the cycle after the start and write nothing.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      illegal_out <= 1'b0;
    end else begin
      illegal_out <= (state == icbx_pkg::ICBX_IDLE) && start_in && !is_known;
    end
  end

  // Sequencer: one execute cycle for register forms, read then write for bit invert.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      // Reset leaves every strobe low and every data output at zero.
      state         <= icbx_pkg::ICBX_IDLE;
      done_out      <= 1'b0;
      next_pc_out   <= 32'h0000_0000;
      reg_we_out    <= 1'b0;
      reg_waddr_out <= 5'h00;
      reg_wdata_out <= 32'h0000_0000;
      flags_out     <= 5'h00;
      flags_we_out  <= 1'b0;
      mem_req_out   <= 1'b0;
      mem_we_out    <= 1'b0;
      mem_addr_out  <= 32'h0000_0000;
      mem_wdata_out <= 8'h00;
    end else begin
      // Done, register write and flag write strobes are one-cycle pulses unless a state raises them again.
      done_out     <= 1'b0;
      reg_we_out   <= 1'b0;
      flags_we_out <= 1'b0;
      case (state)
        icbx_pkg::ICBX_IDLE: begin
          // Latch results and the next program counter at an accepted start.
          if (start_in) begin
            state <= icbx_pkg::ICBX_EXEC;
            if (is_bitop) begin
              mem_addr_out <= bit_addr;
              next_pc_out  <= icbx_pc_after(pc_in, 1'b1);
            end else begin
              next_pc_out  <= icbx_pc_after(pc_in, 1'b0); // [RULE2]
            end
            reg_waddr_out <= second_idx;
            reg_wdata_out <= cmpl_result;
            flags_out     <= is_cmpl ? cmpl_flags : flags_in;
            if (is_bitop) begin
              state       <= icbx_pkg::ICBX_READ;
              mem_req_out <= 1'b1;
              mem_we_out  <= 1'b0;
            end
          end
        end
        icbx_pkg::ICBX_EXEC: begin
          // Idle spends this cycle and asserts no write strobe.
          reg_we_out   <= is_cmpl; // [RULE1] [RULE4]
          flags_we_out <= is_cmpl; // [RULE5]
          done_out     <= 1'b1;
          state        <= icbx_pkg::ICBX_DONE;
        end
        icbx_pkg::ICBX_READ: begin
          // The byte is taken on the first ready of the read phase.
          if (mem_ready_in) begin
            mem_wdata_out <= toggled_byte; // [RULE8]
            mem_we_out    <= 1'b1;
            flags_out[`ICBX_FLAG_NULL] <= !prior_bit; // [RULE9]
            state <= icbx_pkg::ICBX_WRITE;
          end
        end
        icbx_pkg::ICBX_WRITE: begin
          // The write-back ends on its first ready at the same address.
          if (mem_ready_in) begin
            mem_req_out  <= 1'b0;
            mem_we_out   <= 1'b0;
            flags_we_out <= 1'b1; // [RULE9]
            done_out     <= 1'b1;
            state        <= icbx_pkg::ICBX_DONE;
          end
        end
        icbx_pkg::ICBX_DONE: begin
          // One spare cycle before the next start is accepted.
          state <= icbx_pkg::ICBX_IDLE;
        end
        default: begin
          // Any stray code returns to rest.
          state <= icbx_pkg::ICBX_IDLE;
        end
      endcase
    end
  end

endmodule

// *** hdl/icbx_cfg.svh ***
`ifndef ICBX_CFG_SVH
`define ICBX_CFG_SVH
`define ICBX_PC_STEP16      32'h0000_0002
`define ICBX_PC_STEP32      32'h0000_0004
`define ICBX_IDLE_CODE      16'h0000
`define ICBX_OP_CMPL        6'h01
`define ICBX_OP_EXT         6'h3f
`define ICBX_OP_BITI        6'h3e
`define ICBX_BITI_SUB       2'h1
`define ICBX_BITX_SUB       16'h00e2
`define ICBX_ZERO_WORD      32'h0000_0000
`define ICBX_FLAG_CARRY     3'h0
`define ICBX_FLAG_WRAP      3'h1
`define ICBX_FLAG_NEG       3'h2
`define ICBX_FLAG_NULL      3'h3
`define ICBX_FLAG_CLAMP     3'h4
`define ICBX_MSB            5'h1f
`define ICBX_HALF0_HI       5'h0f
`define ICBX_HALF0_LO       5'h00
`define ICBX_HALF1_HI       5'h1f
`define ICBX_HALF1_LO       5'h10
`define ICBX_HALF_MSB       4'hf
`define ICBX_SEXT_BITS      5'h10
`define ICBX_OPC_HI         4'ha
`define ICBX_OPC_LO         4'h5
`define ICBX_SECOND_REGISTER_FIELD_HI        4'hf
`define ICBX_SECOND_REGISTER_FIELD_LO        4'hb
`define ICBX_FORM_HI        4'hf
`define ICBX_FORM_LO        4'he
`define ICBX_BITNO_HI       4'hd
`define ICBX_BITNO_LO       4'hb
`define ICBX_IDX_HI         5'h02
`define ICBX_IDX_LO         5'h00
`define ICBX_BYTE_ONE       8'h01
`endif

// *** hdl/icbx_pkg.sv ***
package icbx_pkg;
  typedef enum logic [2:0] {
    ICBX_IDLE  = 3'h0,
    ICBX_EXEC  = 3'h1,
    ICBX_READ  = 3'h3,
    ICBX_WRITE = 3'h2,
    ICBX_DONE  = 3'h6
  } icbx_state_t;
endpackage

// *** dv/icbx_props.sv ***
`timescale 1ns/1ps
module icbx_props (
  input wire logic        ref_clk_in,
  input wire logic        resetn_in,
  input wire logic        start_in,
  input wire logic        busy_out,
  input wire logic        done_out,
  input wire logic        reg_we_out,
  input wire logic        mem_req_out,
  input wire logic        mem_we_out,
  input wire logic        mem_ready_in,
  input wire logic [31:0] instr_in,
  input wire logic [31:0] first_reg_data_in,
  input wire logic [31:0] reg_wdata_out,
  input wire logic [31:0] mem_addr_out,
  input wire logic [7:0]  mem_rdata_in,
  input wire logic [7:0]  mem_wdata_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  // Accepted start and the offset byte address.
  wire        go  = start_in && !busy_out;
  wire [31:0] adr = first_reg_data_in + {{16{instr_in[31]}}, instr_in[31:16]};
  // Only the two bit invert encodings, not their opcode neighbours.
  wire        imm = (instr_in[10:5] == 6'h3e) && (instr_in[15:14] == 2'h1);
  wire        rgf = (instr_in[10:5] == 6'h3f) && (instr_in[31:16] == 16'h00e2);
  chk_busy_min: assert property (go |=> busy_out[*2]) else $error("short");
  chk_idle_quiet:
    assert property (go && instr_in[15:0] == 16'h0000 |-> ##2 done_out && !reg_we_out && !mem_req_out) else $error("idle");
  chk_cmpl_data:
    assert property (go && instr_in[10:5] == 6'h01 |-> ##2 reg_we_out && reg_wdata_out == ~$past(first_reg_data_in, 2))
    else $error("cmpl");
  chk_imm_addr:
    assert property (go && imm |=> mem_addr_out == $past(adr)) else $error("imm");
  chk_reg_addr:
    assert property (go && rgf |=> mem_addr_out == $past(first_reg_data_in)) else $error("reg");
  chk_read_first:
    assert property (go && (imm || rgf) |=> mem_req_out && !mem_we_out) else $error("read");
  chk_same_addr:
    assert property (mem_req_out && !mem_we_out && mem_ready_in |=> mem_we_out && $stable(mem_addr_out)) else $error("wb");
  chk_one_bit:
    assert property ($rose(mem_we_out) |-> $countones(mem_wdata_out ^ $past(mem_rdata_in)) == 1) else $error("bit");
endmodule

// *** dv/icbx_mem_model.sv ***
`timescale 1ns/1ps
module icbx_mem_model (
  input  wire logic        ref_clk_in,
  input  wire logic        slow_in,
  input  wire logic        req_in,
  input  wire logic        we_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  output logic             ready_out,
  output logic [7:0]       rdata_out
);
  logic [7:0] byte_q [16];
  logic       tick = 1'b0;
  // Slow mode accepts every other cycle; idle read data keeps moving.
  assign ready_out = req_in && (!slow_in || tick);
  assign rdata_out = (ready_out && !we_in) ? byte_q[addr_in[3:0]] : {8{tick}} ^ 8'h5a;
  // Byte k starts as {k, ~k}; a write lands on its accepting edge.
  initial for (int i = 0; i < 16; i++) byte_q[i] = {i[3:0], ~i[3:0]};
  always @(posedge ref_clk_in) begin
    tick <= ~tick;
    if (ready_out && we_in) byte_q[addr_in[3:0]] <= wdata_in;
  end
endmodule

// *** dv/idle_complement_bit_invert_exec_tb_top.sv ***
`timescale 1ns/1ps
module idle_complement_bit_invert_exec_tb_top;
  logic        ref_clk_in = 1'b0, resetn_in = 1'b0, start_in = 1'b0, slow = 1'b0, mem_ready_in, busy_out, done_out;
  logic        illegal_out, reg_we_out, flags_we_out, mem_req_out, mem_we_out;
  logic [31:0] instr_in = '0, pc_in = '0, first_reg_data_in = '0, second_reg_data_in = '0, next_pc_out;
  logic [31:0] reg_wdata_out, mem_addr_out;
  logic [7:0]  mem_rdata_in, mem_wdata_out;
  logic [4:0]  flags_in = 5'h13, reg_waddr_out, flags_out;
  int          error_cnt = 0, n_tests = 0;
  // Core clock at 100 MHz.
  always #5 ref_clk_in = ~ref_clk_in;
  icbx_exec uut (.*);
  icbx_mem_model mem_i (.ref_clk_in, .slow_in(slow), .req_in(mem_req_out), .we_in(mem_we_out), .addr_in(mem_addr_out),
    .wdata_in(mem_wdata_out), .ready_out(mem_ready_in), .rdata_out(mem_rdata_in));
  task automatic chk(input string nm, input logic [39:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Issues one instruction, waits for completion and checks the new pc.
  task automatic go(input logic [31:0] ins, r1, r2, step);
    @(posedge ref_clk_in);
    start_in <= 1'b1;
    instr_in <= ins;
    first_reg_data_in <= r1;
    second_reg_data_in <= r2;
    pc_in <= pc_in + 32'h100;
    @(posedge ref_clk_in);
    start_in <= 1'b0;
    for (int n = 0; n < 40 && done_out !== 1'b1; n++) @(negedge ref_clk_in);
    chk("done", done_out, 1'b1);
    chk("next_pc", next_pc_out, pc_in + step);
  endtask
  task automatic t_idle();
    go(32'hffff_0000, 32'h1, 32'h2, 32'h2);
    chk("idle", {reg_we_out, flags_we_out, mem_req_out}, '0);
  endtask
  task automatic t_cmpl();
    go(32'h0000_1825, 32'hffff_ffff, '0, 32'h2);
    chk("cmpl", {reg_we_out, flags_we_out, reg_waddr_out, flags_out, reg_wdata_out[20:0]},
        {1'b1, 1'b1, 5'h03, 5'h19, 21'h0});
    go(32'h0000_1825, 32'h0000_0001, '0, 32'h2);
    chk("cmpl", {flags_out, reg_wdata_out}, {5'h15, 32'hffff_fffe});
  endtask
  // Toggles one byte bit and checks the stored byte and the flags.
  task automatic bit_case(input logic [31:0] ins, r1, r2, input int a, input logic [12:0] exp);
    go(ins, r1, r2, 32'h4);
    chk("bit", {flags_we_out, flags_out, mem_i.byte_q[a]}, {1'b1, exp});
  endtask
  // An unknown encoding pulses illegal in the cycle after the start and writes nothing.
  task automatic t_bad();
    @(posedge ref_clk_in);
    start_in <= 1'b1;
    instr_in <= 32'h0000_0040;
    @(posedge ref_clk_in);
    start_in <= 1'b0;
    @(negedge ref_clk_in);
    chk("illegal", illegal_out, 1'b1);
    @(negedge ref_clk_in);
    chk("bad", {done_out, reg_we_out, flags_we_out, mem_req_out}, 4'h8);
  endtask
  task automatic t_bits();
    bit_case({16'h0003, 16'h7fc1}, 32'h2, '0, 5, {5'h1b, 8'hda});
    slow <= 1'b1;
    bit_case({16'hffff, 16'h47c2}, 32'h9, '0, 8, {5'h13, 8'h86});
    bit_case({16'h00e2, 16'h27e3}, 32'h2, 32'hffff_fffa, 2, {5'h13, 8'h29});
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Main sequence after two reset cycles.
  initial begin
    repeat (2) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    t_idle();
    t_cmpl();
    t_bad();
    t_bits();
    finish_test();
  end
  // Watchdog well beyond the expected thirty or so cycles.
  initial begin
    #5000;
    error_cnt++;
    finish_test();
  end
endmodule
bind icbx_exec icbx_props chk_i (.*);
